// [pkg/sbr_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SBR_MAP_SVH
`define SBR_MAP_SVH
`define SBR_CH_ADDR_BIT   3
`define SBR_OFS_DIV       3'h0
`define SBR_OFS_STATUS    3'h1
`define SBR_OFS_CTRL      3'h2
`define SBR_DIV_RESET     8'hff
`define SBR_STATUS_RESET  8'h84
`define SBR_BIT_TXEMPTY   7
`define SBR_BIT_TXEND     2
`define SBR_BIT_RXMPB     1
`define SBR_BIT_TXMPB     0
`define SBR_CTRL_CKS_LO   0
`define SBR_CTRL_ASYNC_N  2
`define SBR_CTRL_MP       3
`define SBR_CTRL_TXEN     4
`define SBR_CTRL_RXEN     5
`define SBR_CTRL_EXTCLK   6
`define SBR_CTRL_RESET    8'h00
`define SBR_ASYNC_BIT_T   5'h0f
`define SBR_SYNC_BIT_T    5'h01
`endif

// [pkg/sbr_pkg.sv]
// Types for the serial bit-rate and status block
package sbr_pkg;
    typedef enum logic [1:0] {
        SBR_DIV1,
        SBR_DIV4,
        SBR_DIV16,
        SBR_DIV64
    } sbr_presc_t;

    typedef struct packed {
        logic [7:0] divider;
        logic [7:0] ctrl;
        logic       tx_empty;
        logic       tx_end;
        logic       rx_mpb;
        logic       tx_mpb;
        logic       empty_seen;
        logic [5:0] presc;
        logic [7:0] down;
        logic       gen_phase;
        logic       tick;
        logic [3:0] bitcnt;
        logic       bit_tick;
        logic       tx_mpb_out;
    } sbr_chan_t;
endpackage

// [hw/sbr_core.sv]
// Dual channel bit-rate generator with transmit/multiprocessor status
//
// What this block does
// R1: Software read-then-zero or DMA clears transmit end
// R2: Reset, standby, enable off, last bit set it
// R3: Transmit end reads one after reset
// R4: Received multiprocessor bit captured, read-only
// R5: Receive disable keeps it; resets to zero
// R6: Writable bit zero sent as multiprocessor bit
// R7: That bit ignored when sync, non-MP, idle
// R8: Divider always read/write, FF on reset/standby
// R9: Each channel owns divider and generator
// R10: Prescaler codes pick phi,/4,/16,/64
// R11: Bit period (N+1)*32 or *4 times prescale
// R12: Every divider value 0 to 255 valid
// R13: Zero settings give phi/32 async rate
// R14: External async clock up to phi/4
// R15: External sync clock up to phi/6; sync mode here ignores it and uses the generator
// R16: Fastest sync setting needs no back-to-back
// R17: Transmit empty set on shifter load
// R18: External async clock at sixteen times rate
// R19: Down-counter reloads divider at terminal count
// R20: Async tick runs at sixteen per bit
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sbr_map.svh"
module sbr_core
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       standby,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Transmit and receive engine events and external 16x clock per channel
    input  wire logic [1:0] dma_tx_write,
    input  wire logic [1:0] shifter_load,
    input  wire logic [1:0] last_bit_sent,
    input  wire logic [1:0] rx_mpb_valid,
    input  wire logic [1:0] rx_mpb_value,
    input  wire logic [1:0] ext_clk16_tick,
    // Timing and status outputs per channel
    output logic      [1:0] sample_tick,
    output logic      [1:0] bit_tick,
    output logic      [1:0] tx_mpb_out,
    output logic      [1:0] tx_busy
);

    ////////////////////////////////////////////////////////////////////
    logic [7:0] rdata_q;
    logic [7:0] rd_mux [2];
    assign reg_rdata = rdata_q;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rdata_q <= 8'h00;
        end
        else if (reg_rd)
        begin
            rdata_q <= rd_mux[reg_addr[`SBR_CH_ADDR_BIT]];
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One generator per channel so rates are independent
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) // R9
        begin : g_ch
            sbr_pkg::sbr_chan_t st;
            sbr_pkg::sbr_chan_t next_st;
            logic       sel;
            logic       wr_div;
            logic       wr_sts;
            logic       wr_ctl;
            logic       rd_sts;
            logic       presc_hit;
            logic       gen_tick;
            logic       async;
            logic       mp_fmt;
            logic [4:0] bit_top;
            sbr_pkg::sbr_presc_t cks;
            logic       ext_sel;
            logic       int_tick;
            logic       sts_clear;
            logic       tx_off;
            logic       rx_take;
            logic       mpb_live;
            logic [7:0] sts_word;

            assign sel    = reg_addr[`SBR_CH_ADDR_BIT] == 1'(ch);
            assign wr_div = reg_wr && sel && reg_addr[2:0] == `SBR_OFS_DIV;
            assign wr_sts = reg_wr && sel
                && reg_addr[2:0] == `SBR_OFS_STATUS;
            assign wr_ctl = reg_wr && sel && reg_addr[2:0] == `SBR_OFS_CTRL;
            assign rd_sts = reg_rd && sel
                && reg_addr[2:0] == `SBR_OFS_STATUS;
            assign cks    = sbr_pkg::sbr_presc_t'(
                st.ctrl[`SBR_CTRL_CKS_LO +: 2]);
            assign async  = !st.ctrl[`SBR_CTRL_ASYNC_N];
            assign mp_fmt = async && st.ctrl[`SBR_CTRL_MP];
            // Bit is 16 ticks in async, 2 ticks in sync: 32x versus 4x
            assign bit_top = async ? `SBR_ASYNC_BIT_T : `SBR_SYNC_BIT_T;
            // External 16x clock replaces the generator in async only
            assign ext_sel   = st.ctrl[`SBR_CTRL_EXTCLK] && async;
            // Clear only after software has seen the empty flag set
            assign sts_clear = wr_sts && st.empty_seen
                && !reg_wdata[`SBR_BIT_TXEMPTY];
            assign tx_off    = wr_ctl && !reg_wdata[`SBR_CTRL_TXEN];
            assign rx_take   = rx_mpb_valid[ch] && mp_fmt
                && st.ctrl[`SBR_CTRL_RXEN];
            assign mpb_live  = mp_fmt && st.ctrl[`SBR_CTRL_TXEN]
                && !st.tx_end;
            assign sts_word  = {st.tx_empty, 4'h0, st.tx_end,
                st.rx_mpb, st.tx_mpb};

            always_comb
            begin
                case (cks) // R10
                    sbr_pkg::SBR_DIV1:
                    begin
                        presc_hit = 1'b1;
                    end
                    sbr_pkg::SBR_DIV4:
                    begin
                        presc_hit = st.presc[1:0] == 2'h3;
                    end
                    sbr_pkg::SBR_DIV16:
                    begin
                        presc_hit = st.presc[3:0] == 4'hf;
                    end
                    sbr_pkg::SBR_DIV64:
                    begin
                        presc_hit = st.presc == 6'h3f;
                    end
                    default:
                    begin
                        presc_hit = 1'b1;
                    end
                endcase
            end

            // Terminal count once per (N+1) prescaled periods; N=0 legal
            assign gen_tick = presc_hit && st.down == 8'h00; // R12 R19
            // Second terminal count of each pair gives the tick
            assign int_tick = gen_tick && st.gen_phase;

            ////////////////////////////////////////////////////////////
            always_comb
            begin
                next_st = st;
                next_st.tick = 1'b0;
                next_st.bit_tick = 1'b0;
                if (wr_div)
                begin
                    next_st.divider = reg_wdata; // R8
                end
                if (wr_ctl)
                begin
                    next_st.ctrl = reg_wdata;
                end
                // Prescaler runs free; a setting change may cut one tick
                next_st.presc = st.presc + 6'h01;
                if (presc_hit)
                begin
                    if (st.down == 8'h00)
                    begin
                        next_st.down = st.divider; // R19
                    end
                    else
                    begin
                        next_st.down = st.down - 8'h01;
                    end
                end
                if (gen_tick)
                begin
                    next_st.gen_phase = !st.gen_phase;
                end
                if (ext_sel)
                begin
                    next_st.tick = ext_clk16_tick[ch]; // R18
                end
                else
                begin
                    next_st.tick = int_tick; // R11 R13 R20
                end
                if (next_st.tick)
                begin
                    if (st.bitcnt == bit_top[3:0])
                    begin
                        next_st.bitcnt = 4'h0;
                        next_st.bit_tick = 1'b1; // R11 R16
                    end
                    else
                    begin
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end
                end
                // Status: read of empty-as-1 arms the clear
                if (rd_sts && st.tx_empty)
                begin
                    next_st.empty_seen = 1'b1;
                end
                if (wr_sts)
                begin
                    next_st.tx_mpb = reg_wdata[`SBR_BIT_TXMPB]; // R6
                end
                if (sts_clear)
                begin
                    next_st.tx_empty = 1'b0;
                    next_st.tx_end = 1'b0; // R1
                    next_st.empty_seen = 1'b0;
                end
                // New byte: a stale read must not arm a later clear
                if (dma_tx_write[ch])
                begin
                    next_st.tx_empty = 1'b0;
                    next_st.tx_end = 1'b0; // R1
                    next_st.empty_seen = 1'b0;
                end
                // Hardware set wins over any clear in the same cycle
                if (shifter_load[ch])
                begin
                    next_st.tx_empty = 1'b1; // R17
                end
                if (last_bit_sent[ch] && st.tx_empty)
                begin
                    next_st.tx_end = 1'b1; // R2
                end
                if (tx_off)
                begin
                    next_st.tx_empty = 1'b1;
                    next_st.tx_end = 1'b1; // R2
                end
                // Receive disabled: value held
                if (rx_take)
                begin
                    next_st.rx_mpb = rx_mpb_value[ch]; // R4 R5
                end
                // Bit only used while sending in async MP format
                next_st.tx_mpb_out = mpb_live && next_st.tx_mpb; // R6 R7
            end

            ////////////////////////////////////////////////////////////
            always_ff @(posedge ref_clk)
            begin
                if (!resetn || standby)
                begin
                    st.divider <= `SBR_DIV_RESET; // R8
                    st.ctrl <= `SBR_CTRL_RESET;
                    st.tx_empty <= 1'b1;
                    st.tx_end <= 1'b1; // R2 R3
                    st.rx_mpb <= 1'b0; // R5
                    st.tx_mpb <= 1'b0; // R6
                    st.empty_seen <= 1'b0;
                    st.presc <= 6'h00;
                    st.down <= `SBR_DIV_RESET;
                    st.gen_phase <= 1'b0;
                    st.tick <= 1'b0;
                    st.bitcnt <= 4'h0;
                    st.bit_tick <= 1'b0;
                    st.tx_mpb_out <= 1'b0;
                end
                else
                begin
                    st <= next_st;
                end
            end

            always_comb
            begin
                case (reg_addr[2:0])
                    `SBR_OFS_DIV:
                    begin
                        rd_mux[ch] = st.divider;
                    end
                    `SBR_OFS_STATUS:
                    begin
                        rd_mux[ch] = sts_word; // R4
                    end
                    `SBR_OFS_CTRL:
                    begin
                        rd_mux[ch] = st.ctrl;
                    end
                    default:
                    begin
                        rd_mux[ch] = 8'h00;
                    end
                endcase
            end

            assign sample_tick[ch] = st.tick;
            assign bit_tick[ch]    = st.bit_tick;
            assign tx_mpb_out[ch]  = st.tx_mpb_out;
            assign tx_busy[ch]     = !st.tx_end;
        end
    endgenerate

endmodule

// [tb/sbr_core_asserts.sv]
// Port checker for the bit-rate and status block
`timescale 1ns/1ps
module sbr_core_asserts
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       standby,
    // Register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Channel events and outputs
    input wire logic [1:0] dma_tx_write,
    input wire logic [1:0] last_bit_sent,
    input wire logic [1:0] sample_tick,
    input wire logic [1:0] bit_tick,
    input wire logic [1:0] tx_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_reset_end_set: assert property (disable iff (1'b0)
        !resetn |=> tx_busy == 2'h0) else $error("busy after reset");
    a_standby_end_set: assert property (standby |=> tx_busy == 2'h0)
        else $error("busy after standby");
    a_dma_clears_end: assert property (dma_tx_write[0] && !reg_wr &&
        !standby && !last_bit_sent[0] |=> tx_busy[0])
        else $error("dma write did not clear end flag");
    a_end_set_cause: assert property ($fell(tx_busy[0]) |->
        $past(last_bit_sent[0] | reg_wr | standby))
        else $error("end flag set without cause");
    a_end_clear_cause: assert property ($rose(tx_busy[0]) |->
        $past(dma_tx_write[0] | reg_wr))
        else $error("end flag cleared without cause");
    a_sample_gap: assert property (sample_tick[0] |=> !sample_tick[0])
        else $error("sample ticks back to back");
    a_bit_gap: assert property (bit_tick[0] |=> !bit_tick[0])
        else $error("bit ticks back to back");
    c_dma: cover property (dma_tx_write[0]);
    c_end: cover property ($fell(tx_busy[0]));
    c_bit: cover property (bit_tick[0]);
endmodule
bind sbr_core sbr_core_asserts sbr_core_asserts_i
(
    .ref_clk(ref_clk), .resetn(resetn), .standby(standby),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_tx_write(dma_tx_write), .last_bit_sent(last_bit_sent),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .tx_busy(tx_busy)
);

// [tb/sbr_peer.sv]
// Remote device model making the external 16x serial clock
`timescale 1ns/1ps
module sbr_peer
(
    // Clock and control
    input  wire logic       ref_clk,
    input  wire logic       run,
    // External clock edges
    output logic      [1:0] ext_clk16_tick = 2'h0
);
    logic [2:0] phase = 3'h0;
    // One edge in six cycles stays legal in both modes
    always_ff @(posedge ref_clk)
    begin
        phase <= phase == 3'h5 ? 3'h0 : phase + 3'h1;
        ext_clk16_tick <= {2{run && phase == 3'h5}};
    end
endmodule

// [tb/sbr_core_bench.sv]
// Self-checking bench for the bit-rate and status block
`timescale 1ns/1ps
module sbr_core_bench;
    logic            ref_clk = 1'b0;
    logic            resetn = 1'b0;
    logic            standby = 1'b0;
    logic      [3:0] reg_addr = 4'h0;
    logic      [7:0] reg_wdata = 8'h00;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic      [7:0] reg_rdata;
    logic [4:0][1:0] ev = '0;
    logic            ext_run = 1'b0;
    logic      [1:0] ext_tick, sample_tick, bit_tick, tx_mpb_out, tx_busy;
    logic     [31:0] cyc;
    logic      [7:0] n_val;
    int              mismatches = 0;
    int              check_count = 0;
    int              k;
    initial forever #4 ref_clk = ~ref_clk;
    sbr_core sbr_core_i
    (
        .ref_clk(ref_clk), .resetn(resetn), .standby(standby),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_tx_write(ev[0]),
        .shifter_load(ev[1]), .last_bit_sent(ev[2]), .rx_mpb_valid(ev[3]),
        .rx_mpb_value(ev[4]), .ext_clk16_tick(ext_tick),
        .sample_tick(sample_tick), .bit_tick(bit_tick),
        .tx_mpb_out(tx_mpb_out), .tx_busy(tx_busy)
    );
    sbr_peer sbr_peer_i
    (
        .ref_clk(ref_clk), .run(ext_run), .ext_clk16_tick(ext_tick)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
    endtask
    task automatic pulse(input int i, input logic [1:0] m);
        @(posedge ref_clk);
        ev[i] <= m;
        @(posedge ref_clk);
        ev[i] <= 2'h0;
    endtask
    // First ticks may straddle a setting change, so skip the first two
    task automatic meas(input int c_i, output logic [31:0] c);
        repeat (2) @(posedge ref_clk iff bit_tick[c_i]);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            c++;
        end
        while (bit_tick[c_i] !== 1'b1);
    endtask
    function automatic logic [31:0] per(input logic s, input logic [1:0] n,
                                        input logic [7:0] v);
        per = ({24'h0, v} + 32'h1) * (s ? 32'h4 : 32'h20) << (2 * n);
    endfunction
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h21c3));
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(4'h0, 8'hff);
        rd(4'h1, 8'h84);
        rd(4'h3, 8'h00);
        n_val = 8'($urandom);
        wr(4'h0, n_val);
        wr(4'h8, ~n_val);
        rd(4'h0, n_val);
        rd(4'h8, ~n_val);
        wr(4'h1, 8'h83);
        rd(4'h1, 8'h85);
        wr(4'h2, 8'h18);
        wr(4'h1, 8'h01);
        rd(4'h1, 8'h01);
        chk("tx_mpb_out", 32'h1, {30'h0, tx_mpb_out});
        pulse(1, 2'h1);
        rd(4'h1, 8'h81);
        pulse(2, 2'h1);
        rd(4'h1, 8'h85);
        pulse(0, 2'h1);
        pulse(2, 2'h1);
        rd(4'h1, 8'h01);
        wr(4'h2, 8'h08);
        rd(4'h1, 8'h85);
        chk("tx_mpb_out", 32'h0, {30'h0, tx_mpb_out});
        wr(4'h2, 8'h28);
        ev[4] <= 2'h1;
        pulse(3, 2'h1);
        rd(4'h1, 8'h87);
        wr(4'h2, 8'h08);
        ev[4] <= 2'h0;
        pulse(3, 2'h1);
        wr(4'h1, 8'h85);
        rd(4'h1, 8'h87);
        wr(4'h0, 8'h00);
        for (k = 0; k < 8; k++)
        begin
            wr(4'h2, {5'h0, k[2], k[1:0]});
            meas(0, cyc);
            chk("bit_period", per(k[2], k[1:0], 8'h00), cyc);
        end
        n_val = 8'($urandom_range(0, 5));
        wr(4'h0, n_val);
        wr(4'h2, 8'h01);
        meas(0, cyc);
        chk("bit_period", per(1'b0, 2'h1, n_val), cyc);
        wr(4'h8, 8'h02);
        wr(4'ha, 8'h04);
        meas(1, cyc);
        chk("bit_period_ch1", per(1'b1, 2'h0, 8'h02), cyc);
        ext_run <= 1'b1;
        wr(4'h2, 8'h40);
        meas(0, cyc);
        chk("bit_period", 32'h60, cyc);
        @(posedge ref_clk);
        standby <= 1'b1;
        @(posedge ref_clk);
        standby <= 1'b0;
        rd(4'h8, 8'hff);
        rd(4'h1, 8'h84);
        tally_and_finish();
    end
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
